// ### rtl/location_id_decoder.sv
// Location identifier decoder: straps to slot, crate, rack, address, seed and fan control.
// Assumes strap pins are static jumpers; fan commands come from same-clock logic.
// Function
// R1 - Installed jumper reads zero, absent reads one
// R2 - Low four upper strap bits give slot
// R3 - Bits five and four give crate number
// R4 - Crates two and three pass through unchanged
// R5 - Station rack value equals rack number
// R6 - Baseline racks clear one bit per rack
// R7 - Address first octets fixed at 10.80
// R8 - Third octet 200 or 210 plus rack
// R9 - Last octet 100 times crate+1 plus slot
// R10 - Seed straps set to station rack minus one
// R11 - Seed straps feed every output randomizer
// R12 - Identity straps read zero installed, one absent
// R13 - Identity bit five: station zero, baseline one
// R14 - Identity low bits carry rack number low digits
// R15 - Dual mode: full speed unless both command
// R16 - Single mode: only first controller governs fans
// R17 - Sample straps once after reset, hold
`default_nettype none
module location_id_decoder
  import location_id_pkg::*;
#(
  parameter int NUM_RAND = 16
) (
  input  wire logic                                CLK_SYS,
  input  wire logic                                RSTN,
  input  wire logic [7:0]                          UPPER_STRAP_N,
  input  wire logic [7:0]                          RACK_STRAP_N,
  input  wire logic [location_id_pkg::MON_ID_W-1:0] MON_STRAP_N,
  input  wire logic [location_id_pkg::SEED_W-1:0]   SEED_STRAPS_N,
  input  wire logic                                DUAL_CTRL_STRAP_N,
  input  wire logic                                PCC1_FAN_ACTIVE,
  input  wire logic                                PCC2_FAN_ACTIVE,
  output var  logic [location_id_pkg::SLOT_W-1:0]   SLOT_ID,
  output var  logic [location_id_pkg::CRATE_W-1:0]  CRATE_ID,
  output var  logic [7:0]                          RACK_READ,
  output var  logic [3:0]                          RACK_NUM,
  output var  logic                                RACK_IS_BASELINE,
  output var  logic                                RACK_VALID,
  output var  logic [31:0]                         NET_ADDR,
  output var  logic [location_id_pkg::MON_ID_W-1:0] MON_ID,
  output var  logic [NUM_RAND*8-1:0]               RAND_SEED,
  output var  logic                                FAN_FULL_SPEED,
  output var  logic                                ID_READY
);
  import location_id_pkg::*;

  strap_if st ();

  // Two-flop synchroniser and one-shot capture live in the sampler
  strap_sampler u_sampler (
    .clk       (CLK_SYS),
    .rstn      (RSTN),
    .upper_pin (UPPER_STRAP_N),
    .rack_pin  (RACK_STRAP_N),
    .mon_pin   (MON_STRAP_N),
    .seed_pin  (SEED_STRAPS_N),
    .dual_pin  (DUAL_CTRL_STRAP_N),
    .st        (st)
  );

  // Pins read high when open, so the captured word is already the read value
  logic [7:0] upper_val;
  logic [7:0] rack_val;
  logic [3:0] slot_next;
  logic [1:0] crate_next;
  logic       sta_ok;
  logic       base_ok;
  logic [3:0] base_num;
  logic [7:0] inv_rack;
  logic [3:0] rack_num_next;
  logic [7:0] oct3_next;
  logic [7:0] oct4_next;
  logic [2:0] crate_p1;
  logic       dual_mode;
  logic       fan_full_next;

  assign upper_val  = st.upper;                           // R1
  assign rack_val   = st.rack;                            // R1
  assign slot_next  = upper_val[SLOT_LSB +: SLOT_W];      // R2
  assign crate_next = upper_val[CRATE_LSB +: CRATE_W];    // R3 R4

  // Station: plain number 1..8; baseline: all ones for rack 1, otherwise all ones with one low bit cleared
  assign sta_ok   = (rack_val != 8'h00) && (rack_val <= {4'h0, RACK_MAX}); // R5
  assign inv_rack = ~rack_val;
  // Bit seven is never installed on a baseline rack, so it must read one
  assign base_ok  = (rack_val == RACK_ALL1) ||
                    ((inv_rack & (inv_rack - 8'h01)) == 8'h00 && rack_val[7]); // R6

  always_comb begin
    base_num = 4'h1;
    for (int i = 0; i < 7; i++) begin
      if (inv_rack[i]) base_num = 4'(i + 2); // R6
    end
  end

  assign rack_num_next = sta_ok ? rack_val[3:0] : base_num;
  assign oct3_next = (sta_ok ? STA_BASE : BASE_BASE) + {4'h0, rack_num_next}; // R8
  assign crate_p1  = {1'b0, crate_next} + 3'h1;
  assign oct4_next = 8'(crate_p1 * CRATE_MUL) + {4'h0, slot_next}; // R9

  assign dual_mode = !st.dual_sel;
  assign fan_full_next = dual_mode ? !(PCC1_FAN_ACTIVE && PCC2_FAN_ACTIVE) // R15
                                   : !PCC1_FAN_ACTIVE; // R16

  // Outputs reload from the held capture each cycle, so they cannot drift
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SLOT_ID          <= '0;
      CRATE_ID         <= '0;
      RACK_READ        <= '0;
      RACK_NUM         <= '0;
      RACK_IS_BASELINE <= 1'b0;
      RACK_VALID       <= 1'b0;
      NET_ADDR         <= '0;
      MON_ID           <= '0;
      ID_READY         <= 1'b0;
    end else if (st.held) begin
      SLOT_ID          <= slot_next;  // R2
      CRATE_ID         <= crate_next; // R3 R4
      RACK_READ        <= rack_val;   // R5 R6
      RACK_NUM         <= rack_num_next;
      RACK_IS_BASELINE <= !sta_ok;
      RACK_VALID       <= sta_ok || base_ok;
      NET_ADDR         <= {OCTET1, OCTET2, oct3_next, oct4_next}; // R7
      MON_ID           <= st.mon_id;  // R12 R13 R14
      ID_READY         <= 1'b1;       // R17
    end
  end

  // Every randomizer takes the rack seed; an installed seed jumper means a one,
  // so the pin word is inverted to recover the strapped value
  genvar g;
  generate
    for (g = 0; g < NUM_RAND; g++) begin : g_seed
      always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) RAND_SEED[g*8 +: 8] <= '0;
        else if (st.held) RAND_SEED[g*8 +: 8] <= ~st.seed; // R10 R11
      end
    end
  endgenerate

  // Fan control follows the controllers every cycle; only the mode is latched
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) FAN_FULL_SPEED <= 1'b1;
    else FAN_FULL_SPEED <= fan_full_next;
  end

  addr_fixed_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> NET_ADDR[31:16] == 16'h0a50) else $error("Fixed octets wrong"); // R7
  oct3_rack_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> NET_ADDR[15:8] == (RACK_IS_BASELINE ? 8'hd2 : 8'hc8) + {4'h0, RACK_NUM})
    else $error("Third octet wrong"); // R8
  oct4_slot_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> NET_ADDR[7:0] == 8'(({1'b0, CRATE_ID} + 3'h1) * 8'h64) + {4'h0, SLOT_ID})
    else $error("Final octet wrong"); // R9
  slot_field_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> SLOT_ID == $past(st.upper[3:0])) else $error("Slot field wrong"); // R2
  crate_field_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> CRATE_ID == $past(st.upper[5:4])) else $error("Crate field wrong"); // R3
  station_num_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && !RACK_IS_BASELINE |-> RACK_NUM == RACK_READ[3:0])
    else $error("Station number wrong"); // R5
  mon_id_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> MON_ID == $past(st.mon_id)) else $error("Identity straps wrong"); // R12
  seed_all_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> RAND_SEED[NUM_RAND*8-1 -: 8] == RAND_SEED[7:0])
    else $error("Randomizer seeds differ"); // R11
  fan_dual_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !st.dual_sel && PCC1_FAN_ACTIVE && PCC2_FAN_ACTIVE |=> !FAN_FULL_SPEED)
    else $error("Dual mode fans not released"); // R15
  fan_single_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    st.dual_sel && PCC1_FAN_ACTIVE |=> !FAN_FULL_SPEED)
    else $error("Single mode honoured second controller"); // R16
  ready_holds_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |=> ID_READY && $stable(NET_ADDR)) else $error("Identity changed"); // R17
  ids_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |=> $stable(SLOT_ID) && $stable(CRATE_ID) &&
                 $stable(RACK_NUM) && $stable(MON_ID))
    else $error("Decoded fields changed"); // R17
  seed_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |=> $stable(RAND_SEED))
    else $error("Randomizer seed changed"); // R17
  seed_value_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY |-> RAND_SEED[7:0] == ~$past(st.seed))
    else $error("Randomizer seed not strapped value"); // R11

  // Rack decode
  station_range_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && !RACK_IS_BASELINE |-> RACK_VALID && RACK_NUM >= 4'h1 && RACK_NUM <= 4'h8)
    else $error("Station rack out of range"); // R5
  baseline_first_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && RACK_READ == 8'hff |-> RACK_IS_BASELINE && RACK_VALID && RACK_NUM == 4'h1)
    else $error("First baseline rack wrong"); // R6
  baseline_last_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && RACK_READ == 8'hbf |-> RACK_IS_BASELINE && RACK_VALID && RACK_NUM == 4'h8)
    else $error("Last baseline rack wrong"); // R6
  baseline_bit_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && RACK_IS_BASELINE && RACK_VALID && RACK_NUM != 4'h1 |->
      RACK_READ == ~(8'h01 << (RACK_NUM - 4'h2))) else $error("Baseline bit wrong"); // R6
  illegal_base_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && !RACK_VALID |-> RACK_IS_BASELINE)
    else $error("Illegal pattern taken as station"); // R6

  // Address octets
  oct3_range_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && RACK_VALID |-> NET_ADDR[15:8] inside {[8'hc9:8'hd0], [8'hd3:8'hda]})
    else $error("Third octet out of range"); // R8
  crate_top_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && CRATE_ID == 2'h0 |-> NET_ADDR[7:0] == 8'h64 + {4'h0, SLOT_ID})
    else $error("Top crate octet wrong"); // R9
  crate_bottom_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ID_READY && CRATE_ID == 2'h1 |-> NET_ADDR[7:0] == 8'hc8 + {4'h0, SLOT_ID})
    else $error("Bottom crate octet wrong"); // R9

  // Fan control
  fan_dual_full_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !st.dual_sel && !(PCC1_FAN_ACTIVE && PCC2_FAN_ACTIVE) |=> FAN_FULL_SPEED)
    else $error("Dual mode fans not forced full"); // R15
  fan_single_full_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    st.dual_sel && !PCC1_FAN_ACTIVE |=> FAN_FULL_SPEED)
    else $error("Single mode fans not forced full"); // R16

  cov_baseline_c: cover property (@(posedge CLK_SYS) ID_READY && RACK_IS_BASELINE);
  cov_station_c: cover property (@(posedge CLK_SYS) ID_READY && !RACK_IS_BASELINE);
  cov_single_c: cover property (@(posedge CLK_SYS) st.dual_sel && !PCC1_FAN_ACTIVE);
  cov_crate3_c: cover property (@(posedge CLK_SYS) ID_READY && CRATE_ID == 2'h3);
  cov_dual_c: cover property (@(posedge CLK_SYS)
    st.held && !st.dual_sel && PCC1_FAN_ACTIVE && PCC2_FAN_ACTIVE);
endmodule : location_id_decoder
`default_nettype wire

// ### include/location_id_pkg.sv
// Package for the location identifier decoder: strap field layout and address constants.
// Assumes straps are static jumpers read active low (installed jumper reads zero).
`default_nettype none
package location_id_pkg;
  localparam int SLOT_LSB          = 0;
  localparam int SLOT_W            = 4;
  localparam int CRATE_LSB         = 4;
  localparam int CRATE_W           = 2;
  localparam int RACK_W            = 8;
  localparam int MON_ID_W          = 6;
  localparam int MON_TYPE_BIT      = 5;
  localparam int MON_NUM_W         = 5;
  localparam int SEED_W            = 8;
  localparam logic [7:0] OCTET1    = 8'h0a;  // 10
  localparam logic [7:0] OCTET2    = 8'h50;  // 80
  localparam logic [7:0] STA_BASE  = 8'hc8;  // 200
  localparam logic [7:0] BASE_BASE = 8'hd2;  // 210
  localparam logic [7:0] CRATE_MUL = 8'h64;  // 100
  localparam logic [7:0] RACK_ALL1 = 8'hff;
  localparam logic [3:0] RACK_MAX  = 4'h8;
  localparam logic [1:0] SAMPLE_SETTLE = 2'h3;
  typedef enum logic [1:0] {ST_SYNC, ST_CAPTURE, ST_HOLD} samp_state_e;
endpackage : location_id_pkg
`default_nettype wire

// ### include/strap_if.sv
// Carries the captured strap words from the sampler into the decoder.
// Assumes one clock domain.
`default_nettype none
interface strap_if;
  logic [7:0] upper;
  logic [7:0] rack;
  logic [5:0] mon_id;
  logic [7:0] seed;
  logic       dual_sel;
  logic       held;
  modport sampler (output upper, rack, mon_id, seed, dual_sel, held);
  modport decoder (input upper, rack, mon_id, seed, dual_sel, held);
endinterface : strap_if
`default_nettype wire

// ### rtl/strap_sampler.sv
// Synchronises the raw strap pins and captures them once after reset.
// Assumes straps are static; pins are asynchronous to CLK_SYS.
`default_nettype none
module strap_sampler
  import location_id_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] upper_pin,
  input  wire logic [7:0] rack_pin,
  input  wire logic [5:0] mon_pin,
  input  wire logic [7:0] seed_pin,
  input  wire logic       dual_pin,
  strap_if.sampler        st
);
  localparam int RAW_W = 31;
  logic [RAW_W-1:0] raw;
  logic [RAW_W-1:0] s1_reg;
  logic [RAW_W-1:0] s2_reg;
  logic [RAW_W-1:0] cap_reg;
  logic [1:0]       cnt_reg;
  samp_state_e      state_reg;
  logic             capture;

  assign raw     = {dual_pin, seed_pin, mon_pin, rack_pin, upper_pin};
  assign capture = (state_reg == ST_CAPTURE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  // Wait for the synchroniser to fill, capture once, then hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_SYNC;
      cnt_reg   <= '0;
      cap_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_SYNC: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == SAMPLE_SETTLE) state_reg <= ST_CAPTURE;
        end
        ST_CAPTURE: begin
          cap_reg   <= s2_reg; // R17
          state_reg <= ST_HOLD;
        end
        ST_HOLD: state_reg <= ST_HOLD;
      endcase
    end
  end

  assign st.upper    = cap_reg[7:0];
  assign st.rack     = cap_reg[15:8];
  assign st.mon_id   = cap_reg[21:16];
  assign st.seed     = cap_reg[29:22];
  assign st.dual_sel = cap_reg[30];
  assign st.held     = (state_reg == ST_HOLD);

  held_stable_a: assert property (@(posedge clk) disable iff (!rstn)
    st.held |=> st.held && $stable(cap_reg)) else $error("Straps changed after capture"); // R17
  capture_once_a: assert property (@(posedge clk) disable iff (!rstn)
    capture |=> !capture) else $error("Capture lasted more than one cycle"); // R17
endmodule : strap_sampler
`default_nettype wire

// ### verif/strap_jumpers.sv
// Strap jumper model: turns the set of installed jumpers into pin levels.
// Assumes every strap pin has a pull-up, so an absent jumper reads high.
`default_nettype none
module strap_jumpers (
  input  wire logic [7:0] inst_upper,
  input  wire logic [7:0] inst_rack,
  input  wire logic [5:0] inst_mon,
  input  wire logic [7:0] inst_seed,
  input  wire logic       inst_dual,
  output logic      [7:0] upper_n,
  output logic      [7:0] rack_n,
  output logic      [5:0] mon_n,
  output logic      [7:0] seed_n,
  output logic            dual_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // An installed jumper shorts the pin to ground
  assign upper_n = ~inst_upper;
  assign rack_n  = ~inst_rack;
  assign mon_n   = ~inst_mon;
  assign seed_n  = ~inst_seed;
  assign dual_n  = ~inst_dual;
endmodule : strap_jumpers
`default_nettype wire

// ### verif/tb_location_id_decoder.sv
// Testbench for the location identifier decoder: corner and random locations, fan modes.
// Assumes the strap jumper model and the design package are compiled first.
`default_nettype none
module tb_location_id_decoder;
  import location_id_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NR = 4;
  logic             clk_sys    = 1'b0;
  logic             rstn       = 1'b0;
  logic             pcc1       = 1'b0;
  logic             pcc2       = 1'b0;
  logic [7:0]       inst_upper = 8'h00;
  logic [7:0]       inst_rack  = 8'h00;
  logic [5:0]       inst_mon   = 6'h00;
  logic [7:0]       inst_seed  = 8'h00;
  logic             inst_dual  = 1'b1;
  int               n_fail          = 0;
  int               samples_checked = 0;
  wire logic [7:0]  upper_n;
  wire logic [7:0]  rack_n;
  wire logic [5:0]  mon_n;
  wire logic [7:0]  seed_n;
  wire logic        dual_n;
  wire logic [3:0]  slot_id;
  wire logic [1:0]  crate_id;
  wire logic [7:0]  rack_read;
  wire logic [3:0]  rack_num;
  wire logic        rack_base;
  wire logic        rack_valid;
  wire logic [31:0] net_addr;
  wire logic [5:0]  mon_id;
  wire logic [31:0] rand_seed;
  wire logic        fan;
  wire logic        id_ready;

  always #10 clk_sys = ~clk_sys;

  strap_jumpers strap_jumpers_i (.inst_upper(inst_upper), .inst_rack(inst_rack),
    .inst_mon(inst_mon), .inst_seed(inst_seed), .inst_dual(inst_dual), .upper_n(upper_n),
    .rack_n(rack_n), .mon_n(mon_n), .seed_n(seed_n), .dual_n(dual_n));

  location_id_decoder #(.NUM_RAND(NR)) location_id_decoder_i (.CLK_SYS(clk_sys),
    .RSTN(rstn), .UPPER_STRAP_N(upper_n), .RACK_STRAP_N(rack_n), .MON_STRAP_N(mon_n),
    .SEED_STRAPS_N(seed_n), .DUAL_CTRL_STRAP_N(dual_n), .PCC1_FAN_ACTIVE(pcc1),
    .PCC2_FAN_ACTIVE(pcc2), .SLOT_ID(slot_id), .CRATE_ID(crate_id), .RACK_READ(rack_read),
    .RACK_NUM(rack_num), .RACK_IS_BASELINE(rack_base), .RACK_VALID(rack_valid),
    .NET_ADDR(net_addr), .MON_ID(mon_id), .RAND_SEED(rand_seed), .FAN_FULL_SPEED(fan),
    .ID_READY(id_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // One location: reset, capture, decode, hold against strap changes, then fan modes
  task automatic run_case(input logic b, input logic [3:0] n, input logic [1:0] c,
                          input logic [3:0] s, input logic d);
    logic [7:0]  code;
    logic [31:0] addr;
    code = b ? ((n == 4'h1) ? 8'hff : ~(8'h01 << (n - 4'h2))) : {4'h0, n};
    addr = {8'h0a, 8'h50, (b ? 8'hd2 : 8'hc8) + {4'h0, n},
            8'(({6'h00, c} + 8'h01) * 8'h64 + {4'h0, s})};
    @(posedge clk_sys);
    #1;
    rstn = 1'b0;
    inst_upper = ~{2'($urandom), c, s};
    inst_rack = ~code;
    inst_mon = ~{b, 1'b0, n};
    inst_seed = 8'(n) - 8'h01;
    inst_dual = d;
    repeat (3) @(posedge clk_sys);
    #1;
    check(fan, 1);
    check(id_ready, 0);
    rstn = 1'b1;
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (id_ready === 1'b1) break;
    end
    check(id_ready, 1);
    check(slot_id, s);
    check(crate_id, c);
    check(rack_read, code);
    check(rack_num, n);
    check(rack_base, b);
    check(rack_valid, 1);
    check(net_addr, addr);
    check(mon_id, {b, 1'b0, n});
    check(rand_seed, {NR{8'(n) - 8'h01}});
    // Straps moved after capture must change nothing
    inst_upper = ~inst_upper;
    inst_rack = 8'h00;
    inst_seed = ~inst_seed;
    inst_mon = ~inst_mon;
    inst_dual = ~d;
    repeat (4) @(posedge clk_sys);
    #1;
    check(net_addr, addr);
    check(slot_id, s);
    check(mon_id, {b, 1'b0, n});
    check(rand_seed, {NR{8'(n) - 8'h01}});
    for (int f = 0; f < 4; f++) begin
      pcc1 = f[0];
      pcc2 = f[1];
      @(posedge clk_sys);
      #1;
      check(fan, d ? !(pcc1 && pcc2) : !pcc1);
    end
  endtask : run_case

  initial begin
    void'($urandom(32'h20a9));
    for (int i = 0; i < 16; i++) begin
      run_case(i[0], {1'b0, 3'(i >> 1)} + 4'h1, 2'(i >> 2), {1'b0, 3'(i)}, i[1]);
    end
    for (int i = 0; i < 8; i++) begin
      run_case(1'($urandom), 4'($urandom_range(1, 8)), 2'($urandom),
               4'($urandom_range(0, 7)), 1'($urandom));
    end
    complete_run();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule : tb_location_id_decoder
`default_nettype wire
